// file: rtl/assc_pkg.sv
// package: register map, reset values and timing constants for the scan block
package assc_pkg;
  localparam logic [7:0]  ASSC_OFS_SCAN_LO  = 8'h00;
  localparam logic [7:0]  ASSC_OFS_SCAN_HI  = 8'h04;
  localparam logic [7:0]  ASSC_OFS_CTRL     = 8'h08;
  localparam logic [7:0]  ASSC_OFS_STATUS   = 8'h0C;
  localparam logic [15:0] ASSC_SCAN_RST     = 16'h0000;
  localparam logic [15:0] ASSC_HI_MASK      = 16'h7CFF;
  localparam logic [15:0] ASSC_LO_MASK_20   = 16'hFE1F;
  localparam logic [15:0] ASSC_LO_MASK_28   = 16'hFE3F;
  localparam logic [15:0] ASSC_LO_MASK_44   = 16'hFFFF;
  localparam logic [15:0] ASSC_HI_MASK_20   = 16'h7CE7;
  localparam int          ASSC_CTRL_EN_BIT  = 8;
  localparam int          ASSC_CTRL_START_BIT = 9;
  localparam logic [7:0]  ASSC_DIV_RST      = 8'h00;
  localparam int          ASSC_OSC_PER_CYC  = 2;
  localparam int          ASSC_SAMPLE_TADS  = 1;
  localparam int          ASSC_CONV_TADS    = 14;
  localparam int          ASSC_CH_BITS      = 5;
  typedef enum logic [1:0] {
    ASSC_IDLE,
    ASSC_SAMPLE,
    ASSC_CONVERT
  } assc_state_t;
endpackage : assc_pkg

// file: rtl/assc_scan.sv
// module: input scan selection, conversion clock and scan sequencer
module assc_scan import assc_pkg::*; #(
  parameter int PIN_COUNT = 28
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [4:0]       chan_sel_out,
  output logic             sample_out,
  output logic             convert_out,
  output logic             discharge_out,
  output logic             tad_tick_out
);

  initial begin
    if (PIN_COUNT != 20 && PIN_COUNT != 28 && PIN_COUNT != 44)
      $error("PIN_COUNT must be 20, 28 or 44");
  end

  // --------------------------------------------------------------
  // implemented bit masks per package
  // --------------------------------------------------------------
  localparam logic [15:0] LO_MASK = (PIN_COUNT == 20) ? ASSC_LO_MASK_20 :
                                    (PIN_COUNT == 28) ? ASSC_LO_MASK_28 :
                                    ASSC_LO_MASK_44;
  localparam logic [15:0] HI_MASK = (PIN_COUNT == 20) ? ASSC_HI_MASK_20 :
                                    ASSC_HI_MASK;

  logic [15:0]     scan_lo_r;
  logic [15:0]     scan_hi_r;
  logic [7:0]      div_r;
  logic            scan_en_r;
  logic [31:0]     prdata_r;
  logic            pready_r;
  logic            pslverr_r;
  logic            osc_ph_r;
  logic [7:0]      tad_cnt_r;
  logic            tad_tick_r;
  assc_state_t     state_r;
  logic [4:0]      chan_r;
  logic [4:0]      phase_cnt_r;
  logic            sample_r;
  logic            convert_r;
  logic            disch_r;
  logic            start_pend_r;
  logic [12:0]     smp_cnt_r;
  logic [12:0]     cnv_cnt_r;

  // --------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------
  wire        setup_w   = psel & ~penable;
  wire        wr_w      = setup_w & pwrite;
  wire        hit_lo_w  = (paddr == ASSC_OFS_SCAN_LO);
  wire        hit_hi_w  = (paddr == ASSC_OFS_SCAN_HI);
  wire        hit_ct_w  = (paddr == ASSC_OFS_CTRL);
  wire        hit_st_w  = (paddr == ASSC_OFS_STATUS);
  wire        hit_w     = hit_lo_w | hit_hi_w | hit_ct_w | hit_st_w;
  wire [15:0] lo_nxt    = pwdata[15:0] & LO_MASK;
  wire [15:0] hi_nxt    = pwdata[15:0] & HI_MASK;
  wire        start_w   = wr_w & hit_ct_w & pwdata[ASSC_CTRL_START_BIT];

  // 31-channel include vector; unused positions stay zero
  wire [30:0] incl_w = {scan_hi_r[14:10], scan_hi_r[9:8] & 2'b00,
                        scan_hi_r[7:0], scan_lo_r};

  wire [31:0] rd_w =
    hit_lo_w ? {16'h0000, scan_lo_r} :
    hit_hi_w ? {16'h0000, scan_hi_r} :
    hit_ct_w ? {22'h00_0000, scan_en_r, 1'b0, div_r} :
    hit_st_w ? {25'h000_0000, state_r == ASSC_IDLE, 1'b0, chan_r} :
    32'h0000_0000;

  // ready on the access cycle: one wait-free answer
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~hit_w;
      prdata_r  <= setup_w ? rd_w : 32'h0000_0000;
    end
  end

  // writes commit at the access edge so held data is used
  wire wr_acc_w = psel & penable & pwrite & pready_r;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scan_lo_r <= ASSC_SCAN_RST;
      scan_hi_r <= ASSC_SCAN_RST;
      div_r     <= ASSC_DIV_RST;
      scan_en_r <= 1'b0;
    end else if (wr_acc_w) begin
      if (hit_lo_w) scan_lo_r <= lo_nxt;
      if (hit_hi_w) scan_hi_r <= hi_nxt;
      if (hit_ct_w) begin
        div_r     <= pwdata[7:0];
        scan_en_r <= pwdata[ASSC_CTRL_EN_BIT];
      end
    end
  end

  // --------------------------------------------------------------
  // conversion clock: cycle = 2 sys clocks, tad = cycle*(div+1)
  // --------------------------------------------------------------
  wire cyc_en_w = osc_ph_r;
  // >= ends a stretched tad at once when the divider shrinks
  wire tad_end_w = cyc_en_w & (tad_cnt_r >= div_r);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_ph_r   <= 1'b0;
      tad_cnt_r  <= 8'h00;
      tad_tick_r <= 1'b0;
    end else begin
      osc_ph_r   <= ~osc_ph_r;
      tad_tick_r <= tad_end_w;
      if (tad_end_w) tad_cnt_r <= 8'h00;
      else if (cyc_en_w) tad_cnt_r <= tad_cnt_r + 8'h01;
    end
  end

  // --------------------------------------------------------------
  // scan sequencer
  // --------------------------------------------------------------
  function automatic logic [4:0] next_chan(input logic [30:0] v,
                                           input logic [4:0]  cur);
    logic [4:0] r;
    logic       f;
    r = cur;
    f = 1'b0;
    for (int i = 1; i <= 31; i++) begin
      if (!f && v[5'((32'(cur) + i) % 31)]) begin
        r = 5'((32'(cur) + i) % 31);
        f = 1'b1;
      end
    end
    return r;
  endfunction : next_chan

  wire        any_w   = |incl_w;
  wire [4:0]  first_w = next_chan(incl_w, 5'd30);
  wire [4:0]  step_w  = next_chan(incl_w, chan_r);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r     <= ASSC_IDLE;
      chan_r      <= 5'd0;
      phase_cnt_r <= 5'd0;
      sample_r    <= 1'b0;
      convert_r   <= 1'b0;
      disch_r     <= 1'b0;
      start_pend_r <= 1'b0;
    end else begin
      unique case (state_r)
        ASSC_IDLE: begin
          disch_r <= 1'b1;
          // start waits for a tad edge so the first sample is whole
          if (start_pend_r && tad_end_w) begin
            start_pend_r <= 1'b0;
            if (any_w) begin
              chan_r      <= first_w;
              state_r     <= ASSC_SAMPLE;
              phase_cnt_r <= 5'd0;
              sample_r    <= 1'b1;
            end
          end else if (start_w) start_pend_r <= 1'b1;
        end
        ASSC_SAMPLE: if (tad_end_w) begin
          // sample lasts whole tads before convert
          if (phase_cnt_r == 5'(ASSC_SAMPLE_TADS - 1)) begin
            state_r     <= ASSC_CONVERT;
            phase_cnt_r <= 5'd0;
            sample_r    <= 1'b0;
            convert_r   <= 1'b1;
          end else phase_cnt_r <= phase_cnt_r + 5'd1;
        end
        ASSC_CONVERT: if (tad_end_w) begin
          if (phase_cnt_r == 5'(ASSC_CONV_TADS - 1)) begin
            convert_r <= 1'b0;
            disch_r   <= 1'b1;
            if (scan_en_r && any_w) begin
              chan_r      <= step_w;
              state_r     <= ASSC_SAMPLE;
              sample_r    <= 1'b1;
              phase_cnt_r <= 5'd0;
            end else state_r <= ASSC_IDLE;
          end else phase_cnt_r <= phase_cnt_r + 5'd1;
        end
      endcase
      if (state_r == ASSC_SAMPLE && disch_r) disch_r <= 1'b0;
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign chan_sel_out  = chan_r;
  assign sample_out    = sample_r;
  assign convert_out   = convert_r;
  assign discharge_out = disch_r;
  assign tad_tick_out  = tad_tick_r;

  // --------------------------------------------------------------
  // check helpers: length of the running sample and convert levels
  // --------------------------------------------------------------
  function automatic logic [12:0] tad_len(input logic [7:0] d,
                                          input int         n);
    return 13'(ASSC_OSC_PER_CYC * (int'(d) + 1) * n);
  endfunction : tad_len

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smp_cnt_r <= 13'h0000;
      cnv_cnt_r <= 13'h0000;
    end else begin
      smp_cnt_r <= sample_r ? smp_cnt_r + 13'h0001 : 13'h0000;
      cnv_cnt_r <= convert_r ? cnv_cnt_r + 13'h0001 : 13'h0000;
    end
  end

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  a_hi_unimpl_zero: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (scan_hi_r & ~HI_MASK) == 16'h0000)
    else $error("high word unimplemented bit set");
  a_lo_unimpl_zero: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (scan_lo_r & ~LO_MASK) == 16'h0000)
    else $error("low word unimplemented bit set");
  a_chan_included: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(sample_r) |-> incl_w[chan_r])
    else $error("sampled channel not included");
  a_no_overlap: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) !(sample_r && convert_r))
    else $error("sample and convert overlap");
  a_sample_first: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(convert_r) |-> $past(sample_r))
    else $error("convert without prior sample");
  a_tad_period: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (tad_end_w && div_r == 8'h00 && !wr_acc_w)
      |-> ##1 !tad_end_w ##1 tad_end_w)
    else $error("tad period wrong for divider zero");
  a_cycle_two: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) cyc_en_w |=> !cyc_en_w)
    else $error("instruction cycle not two clocks");
  a_sample_tad: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(sample_r) |-> !tad_end_w)
    else $error("sample shorter than one tad");
  a_scan_wrap: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) ($fell(convert_r) && $rose(sample_r))
      |-> chan_r == $past(step_w))
    else $error("scan order wrong");
  a_pready_pulse: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) pready_r |=> !pready_r)
    else $error("pready longer than one cycle");
  a_pready_setup: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) setup_w |=> pready_r)
    else $error("no answer after setup");
  a_err_ready: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) pslverr_r |-> pready_r)
    else $error("error without ready");
  a_err_data: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) pslverr_r |-> prdata_r == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_disch_idle: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) ($past(rst_n_in) && state_r == ASSC_IDLE &&
      $past(state_r == ASSC_IDLE)) |-> disch_r)
    else $error("idle without discharge");
  a_sample_len: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
      $fell(sample_r) |-> smp_cnt_r == tad_len(div_r, ASSC_SAMPLE_TADS))
    else $error("sample length wrong");
  a_conv_len: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in)
      $fell(convert_r) |-> cnv_cnt_r == tad_len(div_r, ASSC_CONV_TADS))
    else $error("convert length wrong");
  a_tick_pulse: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) tad_tick_r |=> !tad_tick_r)
    else $error("tick longer than one cycle");
  a_tick_follow: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) tad_end_w |=> tad_tick_r)
    else $error("tick missing after tad end");
  a_disch_sample: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(sample_r) |-> disch_r)
    else $error("sample without prior discharge");
  a_chan_stable: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) ((sample_r || convert_r) && !$rose(sample_r))
      |-> $stable(chan_r))
    else $error("channel changed inside a conversion");
  a_idle_quiet: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) state_r == ASSC_IDLE |-> !sample_r && !convert_r)
    else $error("idle with phase active");
  a_scan_stop: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) ($fell(convert_r) && !$rose(sample_r))
      |-> state_r == ASSC_IDLE)
    else $error("scan did not stop");
  a_start_pend: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) start_pend_r |-> state_r == ASSC_IDLE)
    else $error("start pending while busy");
  a_lo_write: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (wr_acc_w && hit_lo_w)
      |=> scan_lo_r == $past(lo_nxt))
    else $error("low word write lost");
  a_hi_write: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (wr_acc_w && hit_hi_w)
      |=> scan_hi_r == $past(hi_nxt))
    else $error("high word write lost");
  a_ct_write: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (wr_acc_w && hit_ct_w)
      |=> div_r == $past(pwdata[7:0]))
    else $error("divider write lost");
  a_err_no_write: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) (wr_acc_w && !hit_w)
      |=> $stable(scan_lo_r) && $stable(scan_hi_r) && $stable(div_r))
    else $error("unmapped write changed a register");
  a_chan_range: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) chan_r <= 5'd30)
    else $error("channel out of range");
  a_phase_bound: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) sample_r |-> phase_cnt_r < 5'(ASSC_SAMPLE_TADS))
    else $error("sample phase count overrun");

endmodule : assc_scan

// file: tb/testbench.sv
// testbench: register masks, refusal and scan sequencing of the scan block
module testbench import assc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // clock, bus and instances
  // ----------------------------------------
  localparam int TAD_CYC = ASSC_OSC_PER_CYC * 2; // divider field 1
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] rd28, rd20, r28, r20, e28;
  logic        rdy28, err28, smp28, cnv28, dis28, tad28;
  logic [4:0]  ch28, c;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          n;
  logic [7:0]  row_a [6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h04};
  logic [15:0] row_d [6] = '{16'hFFFF, 16'h0000, 16'hFFFF, 16'h0000,
                             16'hA5A5, 16'h5A5A};
  logic [15:0] row_28 [6] = '{16'hFE3F, 16'h0000, 16'h7CFF, 16'h0000,
                              16'hA425, 16'h585A};
  logic [15:0] row_20 [6] = '{16'hFE1F, 16'h0000, 16'h7CE7, 16'h0000,
                              16'hA405, 16'h5842};
  always #4 clk = ~clk;
  assc_scan #(.PIN_COUNT(28)) u_assc_scan (.sys_clk_in(clk), .rst_n_in(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(rd28), .pready(rdy28), .pslverr(err28),
    .chan_sel_out(ch28), .sample_out(smp28), .convert_out(cnv28),
    .discharge_out(dis28), .tad_tick_out(tad28));
  // second package variant shares the bus; only its read data is watched
  assc_scan #(.PIN_COUNT(20)) u_assc_scan_20 (.sys_clk_in(clk),
    .rst_n_in(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(rd20), .pready(), .pslverr(),
    .chan_sel_out(), .sample_out(), .convert_out(), .discharge_out(),
    .tad_tick_out());
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task print_verdict;
    if (n_mismatch == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rdy28 !== 1'b1 && i < 20);
    if (rdy28 !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
    r28 = rd28; r20 = rd20; e28 = {31'h0, err28};
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  function automatic logic sig(input int k);
    case (k)
      0: return smp28;
      1: return cnv28;
      default: return tad28;
    endcase
  endfunction : sig
  // level k high: returns its length in cycles and the channel then
  task run_len(input int k, output int len, output logic [4:0] ch);
    int i;
    i = 0;
    while (sig(k) !== 1'b1 && i < 600) begin
      @(posedge clk);
      i++;
    end
    if (i == 600) begin
      n_mismatch++;
      print_verdict();
    end
    ch = ch28; len = 0;
    while (sig(k) === 1'b1 && len < 600) begin
      @(posedge clk);
      len++;
    end
    if (len == 600) begin
      n_mismatch++;
      print_verdict();
    end
  endtask : run_len
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("discharge idle", {31'h0, dis28}, 32'h1);
    for (int a = 0; a < 12; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000);
      chk("reset 28", r28, 32'h0000_0000);
      chk("reset 20", r20, 32'h0000_0000);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, row_a[i], {16'h0000, row_d[i]});
      apb(1'b0, row_a[i], 32'h0000_0000);
      chk("mask 28", r28, {16'h0000, row_28[i]});
      chk("mask 20", r20, {16'h0000, row_20[i]});
    end
    apb(1'b1, 8'h10, 32'hFFFF_FFFF);
    chk("unmapped err", e28, 32'h1);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped data", r28, 32'h0000_0000);
    // channels 0, 4 and 16 enabled; divider 1, continuous, start
    apb(1'b1, ASSC_OFS_SCAN_LO, 32'h0000_0011);
    apb(1'b1, ASSC_OFS_SCAN_HI, 32'h0000_0001);
    apb(1'b1, ASSC_OFS_CTRL, 32'h0000_0301);
    run_len(0, n, c);
    chk("first chan", {27'h0, c}, 32'h0);
    chk("sample len", 32'(n), 32'(ASSC_SAMPLE_TADS * TAD_CYC));
    run_len(1, n, c);
    chk("convert len", 32'(n), 32'(ASSC_CONV_TADS * TAD_CYC));
    run_len(0, n, c);
    chk("second chan", {27'h0, c}, 32'h4);
    run_len(0, n, c);
    chk("high chan", {27'h0, c}, 32'h10);
    run_len(0, n, c);
    chk("wrap chan", {27'h0, c}, 32'h0);
    run_len(2, n, c);
    run_len(2, n, c);
    n = 0;
    while (tad28 !== 1'b1 && n < 600) begin
      @(posedge clk);
      n++;
    end
    chk("tick period", 32'(n + 1), 32'(TAD_CYC));
    // stop the continuous scan, then one single conversion at divider 0
    apb(1'b1, ASSC_OFS_CTRL, 32'h0000_0001);
    n = 0;
    do begin
      apb(1'b0, ASSC_OFS_STATUS, 32'h0000_0000);
      n++;
    end while (r28[6] !== 1'b1 && n < 60);
    chk("scan stops", {31'h0, r28[6]}, 32'h1);
    apb(1'b1, ASSC_OFS_CTRL, 32'h0000_0200);
    run_len(0, n, c);
    chk("single chan", {27'h0, c}, 32'h0);
    chk("single sample", 32'(n), 32'(ASSC_OSC_PER_CYC));
    run_len(1, n, c);
    apb(1'b0, ASSC_OFS_STATUS, 32'h0000_0000);
    chk("single stops", r28, 32'h0000_0040);
    print_verdict();
  end
endmodule : testbench
